// >>> hdl/memory_request_decoder.sv
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
module memory_request_decoder
   import memory_request_decoder_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   // Request pins
   input  wire logic [PIN_W-1:0]  i_request_pins,
   // AHB-Lite slave
   input  wire logic              i_hsel,
   input  wire logic [31:0]       i_haddr,
   input  wire logic [1:0]        i_htrans,
   input  wire logic              i_hwrite,
   input  wire logic [2:0]        i_hsize,
   input  wire logic [31:0]       i_hwdata,
   input  wire logic              i_hready,
   output logic                   o_hreadyout,
   output logic                   o_hresp,
   output logic [31:0]            o_hrdata,
   // Row commands
   output logic                   o_act_valid,
   output logic                   o_act_refresh,
   output logic [2:0]             o_act_bank,
   output logic [ROW_W-1:0]       o_act_row,
   output logic                   o_pre_valid,
   output logic [2:0]             o_pre_bank,
   output logic                   o_refresh_close_valid,
   output logic [2:0]             o_refresh_close_bank,
   // Column commands
   output logic                   o_col_read,
   output logic                   o_col_write,
   output logic                   o_masked_store,
   output logic [2:0]             o_col_bank,
   output logic [5:0]             o_col_addr,
   output logic [7:0]             o_col_mask,
   // Maintenance
   output logic                   o_current_trim,
   output logic                   o_impedance_trim,
   output logic                   o_trim_end,
   output logic                   o_sleep
);

   typedef struct packed {
      logic [PIN_W-1:0] sync1;
      logic [PIN_W-1:0] sync2;
      logic [PIN_W-1:0] first_half;
      phase_t           phase;
      line_t [3:0]      lines;
      logic [ROW_W-1:0] refresh_row;
      logic             enable;
      logic             sleep;
      logic             trim_c;
      logic             trim_z;
      logic             trim_e;
      logic [31:0]      packets;
      logic [31:0]      rdata;
      logic             wr_pend;
      logic [7:0]       wr_addr;
   } state_t;

   state_t s_q;
   state_t s_d;

   // Two clocks per cycle period, so a defer of d cycles lands in slot 2*d
   function automatic logic [2:0] slot_of(input logic [1:0] d);
      return {d, 1'b0};
   endfunction : slot_of

   function automatic line_t advance(input line_t l, input logic ins,
                                     input logic [2:0] slot, input slot_t e);
      line_t r;
      r = l >> LINE_W;
      if (ins) begin
         r[slot] = e;
      end
      return r;
   endfunction : advance

   function automatic logic [31:0] read_reg(input state_t s, input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         REG_CONTROL: v[CTRL_ENABLE_BIT] = s.enable;
         REG_STATUS:  v = {20'h0_0000, s.refresh_row, s.sleep};
         REG_PACKETS: v = s.packets;
         default:     v = 32'h0000_0000;
      endcase
      return v;
   endfunction : read_reg

   logic [PKT_W-1:0] pkt;
   logic             dec;
   logic [3:0]       kind;
   logic             is_act;
   logic             is_col;
   logic             is_mask;
   logic             is_ext;
   logic             is_pr;
   logic [2:0]       pre_sub;
   logic [2:0]       ref_sub;
   logic [7:0]       ref_arg;
   logic [3:0]       ext_code;
   logic             ins_act;
   logic             ins_col;
   logic             ins_pre;
   logic             ins_rpre;
   logic             incr_now;
   logic             load_low;
   logic             load_mid;
   logic             addr_phase;
   logic             sleep_clear;
   slot_t            act_e;
   slot_t            col_e;
   logic [2:0]       act_slot;
   logic [2:0]       col_slot;

   always_comb begin
      s_d = s_q;
      // First flop feeds only the second
      s_d.sync1 = i_request_pins;
      s_d.sync2 = s_q.sync1;
      pkt      = {s_q.first_half, s_q.sync2};
      dec      = s_q.enable && (s_q.phase == PHASE_SECOND);
      kind     = pkt[KIND_MSB -: 4];
      pre_sub  = pkt[PRE_SUB_MSB -: 3];
      ref_sub  = pkt[REF_SUB_MSB -: 3];
      ref_arg  = pkt[REF_ARG_MSB -: 8];
      ext_code = pkt[EXT_CODE_MSB -: 4];
      // Idle kind matches none of these
      is_act   = dec && (kind[3:2] == KIND_ACT_TOP);
      is_col   = dec && (kind == KIND_COLUMN);
      is_mask  = dec && kind[3];
      is_ext   = dec && (kind == KIND_EXTENDED);
      is_pr    = dec && (kind == KIND_PRE_REF);
      // Activate line: ordinary and refresh activates share it
      ins_act  = is_act || (is_pr && ((ref_sub == REFRESH_OPEN) ||
                                      (ref_sub == REFRESH_OPEN_INCR)));
      act_e    = '0;
      act_e[LINE_W-1] = 1'b1;
      if (is_act) begin
         act_e[13:0] = {pkt[ACT_BANK_MSB -: 3], pkt[ACT_ROW_MSB -: ROW_W]};
         act_slot    = slot_of({1'b0, pkt[ACT_DEFER_BIT]});
      end else begin
         act_e[15]   = 1'b1;
         act_e[14]   = (ref_sub == REFRESH_OPEN_INCR);
         act_e[13:0] = {ref_arg[2:0], s_q.refresh_row};
         act_slot    = slot_of(ref_arg[7:6]);
      end
      // Column line: read, write, masked store
      ins_col = is_col || is_mask;
      col_e   = '0;
      if (is_mask) begin
         col_e    = {1'b1, COL_MASKED, pkt[MASK_BANK_MSB -: 3], pkt[COL_ADDR_MSB -: 6],
                     pkt[MASK_MSB -: 8]};
         col_slot = 3'h0;
      end else begin
         col_e    = {1'b1, pkt[DIRECTION_BIT] ? COL_WRITE : COL_READ,
                     pkt[COL_BANK_MSB -: 3], pkt[COL_ADDR_MSB -: 6], 8'hFF};
         col_slot = slot_of({1'b0, pkt[COL_DEFER_BIT]});
      end
      // Precharge and refresh close run on separate lines so both execute
      ins_pre  = is_pr && pre_sub[2];
      ins_rpre = is_pr && (ref_sub == REFRESH_CLOSE_BANK);
      s_d.lines[LINE_ACT]  = advance(s_q.lines[LINE_ACT], ins_act, act_slot, act_e);
      s_d.lines[LINE_COL]  = advance(s_q.lines[LINE_COL], ins_col, col_slot, col_e);
      s_d.lines[LINE_PRE]  = advance(s_q.lines[LINE_PRE], ins_pre, slot_of(pre_sub[1:0]),
                                     {1'b1, 16'h0000, pkt[CLOSE_BANK_MSB -: 3]});
      s_d.lines[LINE_RPRE] = advance(s_q.lines[LINE_RPRE], ins_rpre, slot_of(ref_arg[7:6]),
                                     {1'b1, 16'h0000, ref_arg[2:0]});
      // Refresh row: increment as the activate leaves, loads override
      incr_now = s_q.lines[LINE_ACT][0][LINE_W-1] && s_q.lines[LINE_ACT][0][14];
      load_low = is_pr && (ref_sub == LOAD_LOW_REFRESH_ROW);
      load_mid = is_pr && (ref_sub == LOAD_MID_REFRESH_ROW);
      if (incr_now) begin
         s_d.refresh_row = s_q.refresh_row + 11'h001;
      end
      if (load_low) begin
         s_d.refresh_row[7:0] = ref_arg;
      end
      if (load_mid) begin
         s_d.refresh_row[10:8] = ref_arg[2:0];
      end
      // Extended codes other than the three trims and sleep entry fall through as no operation
      s_d.trim_c = is_ext && (ext_code == EXT_CURRENT_TRIM);
      s_d.trim_z = is_ext && (ext_code == EXT_IMPEDANCE_TRIM);
      s_d.trim_e = is_ext && (ext_code == EXT_TRIM_END);
      // Phase restarts on enable so software aligns packet framing
      if (!s_q.enable) begin
         s_d.phase = PHASE_FIRST;
      end else if (s_q.phase == PHASE_FIRST) begin
         s_d.phase      = PHASE_SECOND;
         s_d.first_half = s_q.sync2;
      end else begin
         s_d.phase = PHASE_FIRST;
      end
      if (dec) begin
         s_d.packets = s_q.packets + 32'h0000_0001;
      end
      // Bus slave; zero wait states, read data snapshot in address phase
      addr_phase  = i_hsel && i_htrans[1] && i_hready;
      s_d.wr_pend = addr_phase && i_hwrite;
      s_d.wr_addr = i_haddr[7:0];
      if (addr_phase && !i_hwrite) begin
         s_d.rdata = read_reg(s_q, i_haddr[7:0]);
      end
      sleep_clear = 1'b0;
      if (s_q.wr_pend && (s_q.wr_addr == REG_CONTROL)) begin
         s_d.enable  = i_hwdata[CTRL_ENABLE_BIT];
         sleep_clear = i_hwdata[CTRL_SLEEP_CLEAR_BIT];
      end
      // Entry wins over a clear in the same cycle
      s_d.sleep = (is_ext && (ext_code == EXT_SLEEP_ENTRY)) || (s_q.sleep && !sleep_clear);
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         s_q             <= '0;
         s_q.phase       <= PHASE_FIRST;
         s_q.enable      <= CTRL_ENABLE_RESET;
         s_q.refresh_row <= REFRESH_ROW_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_hreadyout           = 1'b1;
   assign o_hresp               = 1'b0;
   assign o_hrdata              = s_q.rdata;
   assign o_act_valid           = s_q.lines[LINE_ACT][0][LINE_W-1];
   assign o_act_refresh         = s_q.lines[LINE_ACT][0][15];
   assign o_act_bank            = s_q.lines[LINE_ACT][0][13:11];
   assign o_act_row             = s_q.lines[LINE_ACT][0][10:0];
   assign o_pre_valid           = s_q.lines[LINE_PRE][0][LINE_W-1];
   assign o_pre_bank            = s_q.lines[LINE_PRE][0][2:0];
   assign o_refresh_close_valid = s_q.lines[LINE_RPRE][0][LINE_W-1];
   assign o_refresh_close_bank  = s_q.lines[LINE_RPRE][0][2:0];
   assign o_col_read     = s_q.lines[LINE_COL][0][LINE_W-1] && (s_q.lines[LINE_COL][0][18:17] == COL_READ);
   assign o_col_write    = s_q.lines[LINE_COL][0][LINE_W-1] && (s_q.lines[LINE_COL][0][18:17] == COL_WRITE);
   assign o_masked_store = s_q.lines[LINE_COL][0][LINE_W-1] && (s_q.lines[LINE_COL][0][18:17] == COL_MASKED);
   assign o_col_bank       = s_q.lines[LINE_COL][0][16:14];
   assign o_col_addr       = s_q.lines[LINE_COL][0][13:8];
   assign o_col_mask       = s_q.lines[LINE_COL][0][7:0];
   assign o_current_trim   = s_q.trim_c;
   assign o_impedance_trim = s_q.trim_z;
   assign o_trim_end       = s_q.trim_e;
   assign o_sleep          = s_q.sleep;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   AST_PHASE_PAIRS: assert property (dec |=> !dec)
      else $error("packets decoded on adjacent clocks");
   AST_IDLE_NO_CMD: assert property (dec && kind == KIND_IDLE |->
      !(ins_act || ins_col || ins_pre || ins_rpre) ##1 !(o_sleep && !$past(s_q.sleep)))
      else $error("idle packet produced a command");
   AST_READ_DEFER1: assert property (is_col && !pkt[DIRECTION_BIT] && pkt[COL_DEFER_BIT]
      |-> ##3 (o_col_read && o_col_bank == $past(pkt[COL_BANK_MSB -: 3], 3)))
      else $error("deferred column read late or wrong bank");
   AST_WRITE_NOW: assert property (is_col && pkt[DIRECTION_BIT] && !pkt[COL_DEFER_BIT]
      |=> o_col_write && !o_col_read && o_col_mask == 8'hFF)
      else $error("column write not issued next clock");
   AST_ACT_ROW: assert property (is_act && !pkt[ACT_DEFER_BIT]
      |=> o_act_valid && !o_act_refresh && o_act_row == $past(pkt[ACT_ROW_MSB -: ROW_W]))
      else $error("activate row mismatch");
   AST_MASK_PASS: assert property (is_mask |=> o_masked_store &&
      o_col_mask == $past(pkt[MASK_MSB -: 8]))
      else $error("masked store mask lost");
   AST_REFCLOSE_D3: assert property (ins_rpre && ref_arg[7:6] == 2'h3
      |-> ##7 o_refresh_close_valid)
      else $error("refresh close not deferred by three cycles");
   AST_LOAD_LOW: assert property (load_low |=> s_q.refresh_row[7:0] == $past(ref_arg))
      else $error("low refresh row not loaded");
   AST_LOAD_MID: assert property (load_mid |=> s_q.refresh_row[10:8] == $past(ref_arg[2:0]))
      else $error("mid refresh row not loaded");
   AST_RESERVED_KEEP: assert property (is_pr && ref_sub[2:1] == 2'h3 && !incr_now
      |=> $stable(s_q.refresh_row))
      else $error("reserved refresh subcode changed row");
   AST_INCR_AFTER: assert property (incr_now && !load_low && !load_mid
      |=> s_q.refresh_row == $past(s_q.refresh_row) + 11'h001)
      else $error("refresh row not incremented");
   AST_PRE_D2: assert property (is_pr && pre_sub == 3'h6 |-> ##5 (o_pre_valid &&
      o_pre_bank == $past(pkt[CLOSE_BANK_MSB -: 3], 5)))
      else $error("precharge defer or bank wrong");
   AST_BOTH_EXEC: assert property (is_pr && pre_sub == 3'h4 && ref_sub == REFRESH_CLOSE_BANK &&
      ref_arg[7:6] == 2'h0 |=> o_pre_valid && o_refresh_close_valid)
      else $error("combined precharge and refresh not both issued");
   AST_SLEEP_ENTRY: assert property (is_ext && ext_code == EXT_SLEEP_ENTRY |=> o_sleep)
      else $error("sleep entry missed");
   AST_TRIM_RSVD: assert property (is_ext && ext_code[3] == 1'b0
      |=> !o_current_trim && !o_impedance_trim && !o_trim_end)
      else $error("reserved extended code acted");

endmodule : memory_request_decoder

// >>> pkg/memory_request_decoder_pkg.sv
package memory_request_decoder_pkg;

   // Packet geometry
   localparam int PIN_W   = 12;
   localparam int PKT_W   = 24;
   localparam int SLOTS   = 7;
   localparam int LINE_W  = 20;
   localparam int ROW_W   = 11;

   // Packet kind codes
   localparam logic [3:0] KIND_IDLE     = 4'h0;
   localparam logic [3:0] KIND_COLUMN   = 4'h1;
   localparam logic [3:0] KIND_EXTENDED = 4'h2;
   localparam logic [3:0] KIND_PRE_REF  = 4'h3;
   localparam logic [1:0] KIND_ACT_TOP  = 2'h1;

   // Field positions, most significant bit of each field
   localparam int KIND_MSB       = 23;
   localparam int ACT_DEFER_BIT  = 19;
   localparam int ACT_BANK_MSB   = 18;
   localparam int ACT_ROW_MSB    = 10;
   localparam int DIRECTION_BIT  = 19;
   localparam int COL_DEFER_BIT  = 18;
   localparam int COL_BANK_MSB   = 17;
   localparam int MASK_BANK_MSB  = 18;
   localparam int COL_ADDR_MSB   = 13;
   localparam int MASK_MSB       = 7;
   localparam int EXT_CODE_MSB   = 3;
   localparam int PRE_SUB_MSB    = 19;
   localparam int CLOSE_BANK_MSB = 16;
   localparam int REF_SUB_MSB    = 13;
   localparam int REF_ARG_MSB    = 7;

   // Refresh subcodes
   typedef enum logic [2:0] {
      REFRESH_IDLE         = 3'h0,
      REFRESH_CLOSE_BANK   = 3'h1,
      REFRESH_OPEN         = 3'h2,
      REFRESH_OPEN_INCR    = 3'h3,
      LOAD_LOW_REFRESH_ROW = 3'h4,
      LOAD_MID_REFRESH_ROW = 3'h5,
      LOAD_HIGH_REFRESH_ROW = 3'h6,
      REFRESH_RESERVED     = 3'h7
   } refresh_subcode_t;

   // Extended codes
   localparam logic [3:0] EXT_CURRENT_TRIM   = 4'h8;
   localparam logic [3:0] EXT_IMPEDANCE_TRIM = 4'h9;
   localparam logic [3:0] EXT_TRIM_END       = 4'hA;
   localparam logic [3:0] EXT_SLEEP_ENTRY    = 4'hC;

   // Column operations held in the column line
   localparam logic [1:0] COL_READ   = 2'h1;
   localparam logic [1:0] COL_WRITE  = 2'h2;
   localparam logic [1:0] COL_MASKED = 2'h3;

   // Delay lines
   localparam int LINE_ACT  = 0;
   localparam int LINE_COL  = 1;
   localparam int LINE_PRE  = 2;
   localparam int LINE_RPRE = 3;

   // Register map
   localparam logic [7:0]  REG_CONTROL = 8'h00;
   localparam logic [7:0]  REG_STATUS  = 8'h04;
   localparam logic [7:0]  REG_PACKETS = 8'h08;
   localparam int          CTRL_ENABLE_BIT      = 0;
   localparam int          CTRL_SLEEP_CLEAR_BIT = 1;
   localparam logic        CTRL_ENABLE_RESET    = 1'h0;
   localparam logic [10:0] REFRESH_ROW_RESET    = 11'h000;

   typedef enum logic {
      PHASE_FIRST  = 1'b0,
      PHASE_SECOND = 1'b1
   } phase_t;

   typedef logic [LINE_W-1:0] slot_t;
   typedef slot_t [SLOTS-1:0] line_t;

endpackage : memory_request_decoder_pkg

// >>> testbench/request_source.sv
`timescale 1ns/1ns
module request_source
   import memory_request_decoder_pkg::*;
(
   // Clock
   input  wire logic          i_clock,
   // Request pins toward the device
   output logic [PIN_W-1:0]   o_request_pins
);
   logic             slot_q = 1'b0;
   logic [PKT_W-1:0] cur_q  = '0;
   int               n_sent = 0;
   logic [PKT_W-1:0] pend[$];

   task automatic queue_pkt(input logic [PKT_W-1:0] p);
      pend.push_back(p);
   endtask : queue_pkt

   initial o_request_pins = '0;

   // Idle packets fill every gap, so framing never drifts after alignment
   always @(posedge i_clock) begin
      slot_q <= ~slot_q;
      if (slot_q == 1'b0) begin
         cur_q = '0;
         if (pend.size() > 0) begin
            cur_q = pend.pop_front();
         end
         o_request_pins <= cur_q[PKT_W-1:PIN_W];
      end else begin
         o_request_pins <= cur_q[PIN_W-1:0];
         if (cur_q != '0) begin
            n_sent <= n_sent + 1;
         end
      end
   end
endmodule : request_source

// >>> testbench/memory_request_decoder_tb.sv
`timescale 1ns/1ns
module memory_request_decoder_tb;
   import memory_request_decoder_pkg::*;
   localparam int LIMIT = 6000;
   logic             i_clock = 1'b0;
   logic             i_rst = 1'b1;
   logic             i_hsel = 1'b0, i_hwrite = 1'b0;
   logic [1:0]       i_htrans = 2'h0;
   logic [2:0]       i_hsize = 3'h2;
   logic [31:0]      i_haddr = 32'h0000_0000, i_hwdata = 32'h0000_0000;
   wire [PIN_W-1:0]  i_request_pins;
   logic             o_hreadyout, o_hresp, o_act_valid, o_act_refresh, o_pre_valid;
   logic             o_refresh_close_valid, o_col_read, o_col_write, o_masked_store;
   logic             o_current_trim, o_impedance_trim, o_trim_end, o_sleep;
   logic [31:0]      o_hrdata;
   logic [2:0]       o_act_bank, o_pre_bank, o_refresh_close_bank, o_col_bank;
   logic [ROW_W-1:0] o_act_row;
   logic [5:0]       o_col_addr;
   logic [7:0]       o_col_mask;
   int               n_errors = 0;
   int               cmp_count = 0;
   int               cyc = 0;
   wire [8:0]        pv = {o_trim_end, o_impedance_trim, o_current_trim, o_masked_store,
                           o_col_write, o_col_read, o_refresh_close_valid, o_pre_valid,
                           o_act_valid};

   memory_request_decoder uut (
      .i_clock, .i_rst, .i_request_pins, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
      .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata,
      .o_act_valid, .o_act_refresh, .o_act_bank, .o_act_row, .o_pre_valid, .o_pre_bank,
      .o_refresh_close_valid, .o_refresh_close_bank, .o_col_read, .o_col_write,
      .o_masked_store, .o_col_bank, .o_col_addr, .o_col_mask, .o_current_trim,
      .o_impedance_trim, .o_trim_end, .o_sleep
   );

   request_source src (
      .i_clock,
      .o_request_pins(i_request_pins)
   );

   always #20 i_clock = ~i_clock;

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // A hang anywhere ends up here as a mismatch
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Single transfer; holds each phase until hready is seen high
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge i_clock);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_haddr <= a;
      i_hwrite <= wr;
      @(posedge i_clock);
      while (o_hreadyout !== 1'b1) @(posedge i_clock);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      @(posedge i_clock);
      while (o_hreadyout !== 1'b1) @(posedge i_clock);
      r = o_hrdata;
      chk(32'(o_hresp), 32'h0000_0000);
   endtask : ahb

   function automatic logic [31:0] fld(input int s);
      case (s)
         0: fld = 32'({o_act_refresh, o_act_bank, o_act_row});
         1: fld = 32'(o_pre_bank);
         2: fld = 32'(o_refresh_close_bank);
         3, 4, 5: fld = 32'({o_col_bank, o_col_addr, o_col_mask});
         default: fld = 32'h0000_0000;
      endcase
   endfunction : fld

   // Sends one packet; selector 15 means no command expected
   task automatic send(input logic [23:0] pkt, input int sa, input int ka,
                       input logic [31:0] fa, input int sb = 15, input int kb = 0,
                       input logic [31:0] fb = 32'h0000_0000);
      int n0;
      logic [15:0] ev;
      n0 = src.n_sent;
      src.queue_pkt(pkt);
      while (src.n_sent == n0) begin
         @(posedge i_clock);
         #1;
      end
      // Low word seen at edge 1; decode lands at edge 3, first pulse at edge 4
      for (int k = 2; k <= 13; k++) begin
         @(posedge i_clock);
         #1;
         ev = 16'h0000;
         if (k == ka) ev[sa] = 1'b1;
         if (k == kb) ev[sb] = 1'b1;
         chk(32'(pv), 32'(ev[8:0]));
         if (k == ka && sa < 9) chk(fld(sa), fa);
         if (k == kb && sb < 9) chk(fld(sb), fb);
      end
   endtask : send

   initial begin
      logic [31:0] r;
      int s;
      repeat (5) @(posedge i_clock);
      i_rst <= 1'b0;
      #1;
      chk(32'(pv), 32'h0000_0000);
      chk(32'(o_sleep), 32'h0000_0000);
      ahb(1'b0, 32'(REG_CONTROL), 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      ahb(1'b0, 32'(REG_STATUS), 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      ahb(1'b0, 32'(REG_PACKETS), 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      // Enable lands so that the next high word starts a packet
      do begin
         @(posedge i_clock);
         #1;
      end while (src.slot_q !== 1'b0);
      ahb(1'b1, 32'(REG_CONTROL), 32'h0000_0001, r);
      send({4'h4, 1'b0, 3'h5, 5'h00, 11'h2A5}, 0, 4, {1'b0, 3'h5, 11'h2A5});
      send({4'h7, 1'b1, 3'h2, 5'h00, 11'h7FF}, 0, 6, {1'b0, 3'h2, 11'h7FF});
      send({4'h1, 2'h0, 3'h3, 1'b0, 6'h2A, 8'h00}, 3, 4, {3'h3, 6'h2A, 8'hFF});
      send({4'h1, 2'h3, 3'h6, 1'b0, 6'h15, 8'h00}, 4, 6, {3'h6, 6'h15, 8'hFF});
      send({4'hB, 1'b0, 3'h4, 2'h0, 6'h3F, 8'hA5}, 5, 4, {3'h4, 6'h3F, 8'hA5});
      for (int d = 0; d < 4; d++) begin
         send({4'h3, 1'b1, d[1:0], 3'(d + 1), 6'h00, 8'h00}, 1, 4 + 2 * d, d + 1);
         send({4'h3, 6'h00, 6'h08, d[1:0], 3'h0, 3'(7 - d)}, 2, 4 + 2 * d, 7 - d);
      end
      send({4'h3, 3'h5, 3'h6, 6'h08, 8'hC2}, 1, 6, 32'h0000_0006, 2, 10, 32'h0000_0002);
      send({4'h3, 6'h00, 6'h20, 8'h5A}, 15, 0, 0);
      send({4'h3, 6'h00, 6'h28, 8'hFB}, 15, 0, 0);
      ahb(1'b0, 32'(REG_STATUS), 32'h0000_0000, r);
      chk(r, 32'h0000_06B4);
      send({4'h3, 6'h00, 6'h10, 8'h81}, 0, 8, {1'b1, 3'h1, 11'h35A});
      send({4'h3, 6'h00, 6'h18, 8'h04}, 0, 4, {1'b1, 3'h4, 11'h35A});
      send({4'h3, 6'h00, 6'h30, 8'hFF}, 15, 0, 0);
      send({4'h3, 6'h00, 6'h38, 8'hFF}, 15, 0, 0);
      ahb(1'b0, 32'(REG_STATUS), 32'h0000_0000, r);
      chk(r, 32'h0000_06B6);
      send({4'h3, 6'h07, 6'h00, 8'hFF}, 15, 0, 0);
      for (int p = 1; p < 4; p++) begin
         send({4'h3, p[2:0], 3'h7, 6'h00, 8'hFF}, 15, 0, 0);
      end
      send({4'h0, 20'hF_FFFF}, 15, 0, 0);
      for (int c = 0; c < 16; c++) begin
         s = (c == 8) ? 6 : (c == 9) ? 7 : (c == 10) ? 8 : 15;
         if (c != 12) send({4'h2, 16'h0000, c[3:0]}, s, 4, 0);
      end
      chk(32'(o_sleep), 32'h0000_0000);
      send({4'h2, 16'h0000, 4'hC}, 15, 0, 0);
      chk(32'(o_sleep), 32'h0000_0001);
      ahb(1'b0, 32'(REG_STATUS), 32'h0000_0000, r);
      chk(r, 32'h0000_06B7);
      ahb(1'b1, 32'(REG_CONTROL), 32'h0000_0003, r);
      ahb(1'b0, 32'(REG_STATUS), 32'h0000_0000, r);
      chk(r, 32'h0000_06B6);
      ahb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, r);
      ahb(1'b0, 32'h0000_0010, 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      ahb(1'b0, 32'(REG_CONTROL), 32'h0000_0000, r);
      chk(r, 32'h0000_0001);
      tally_and_finish();
   end
endmodule : memory_request_decoder_tb
